//--- common/cpr_pkg.sv
// Purpose: shared constants and types for the card register decode block
// Assumes: byte-wide attribute registers, 11 address lines
// Notes:   task file register contents live outside this block
package cpr_pkg;

  localparam logic [10:0] CPR_PIN_REPL_ADDR  = 11'h204;
  localparam logic [10:0] CPR_SOCK_COPY_ADDR = 11'h206;
  localparam logic [10:0] CPR_CFG_OPT_ADDR   = 11'h200;
  localparam logic [7:0]  CPR_PIN_REPL_RST   = 8'h0c;
  localparam logic [7:0]  CPR_SOCK_COPY_RST  = 8'h00;
  localparam logic [7:0]  CPR_CFG_OPT_RST    = 8'h00;
  localparam logic [7:0]  CPR_PIN_FIXED_ONES = 8'h0c;
  localparam int          CPR_RDY_CHG_BIT    = 5;
  localparam int          CPR_WP_CHG_BIT     = 4;
  localparam int          CPR_RDY_BIT        = 1;
  localparam int          CPR_WP_BIT         = 0;
  localparam int          CPR_COPY_BIT       = 4;
  localparam logic [5:0]  CPR_PRI_HI_1F      = 6'h1f;
  localparam logic [5:0]  CPR_PRI_HI_3F      = 6'h3f;
  localparam logic [3:0]  CPR_OFS_DATA       = 4'h0;
  localparam logic [3:0]  CPR_OFS_DUP_EVEN   = 4'h8;
  localparam logic [3:0]  CPR_OFS_DUP_ODD    = 4'h9;
  localparam logic [3:0]  CPR_OFS_ALT        = 4'he;
  localparam logic [3:0]  CPR_OFS_DRV_ADDR   = 4'hf;
  localparam logic [5:0]  CPR_IDX_MEMORY     = 6'h00;
  localparam logic [5:0]  CPR_IDX_CONTIG     = 6'h01;
  localparam logic [5:0]  CPR_IDX_PRIMARY    = 6'h02;
  localparam logic [5:0]  CPR_IDX_SECONDARY  = 6'h03;

  typedef enum logic [2:0] {
    CPR_MAP_MEMORY  = 3'b000,
    CPR_MAP_CONTIG  = 3'b001,
    CPR_MAP_PRIMARY = 3'b011,
    CPR_MAP_SECOND  = 3'b010,
    CPR_MAP_IDE     = 3'b110
  } cpr_map_t;

  typedef struct packed {
    logic [10:0] addr;
    logic        reg_sel_n;
    logic        oe_n;
    logic        we_n;
    logic        io_read_strobe_n;
    logic        io_write_strobe_n;
  } cpr_host_bus_t;

  typedef struct packed {
    logic       hit;
    logic       rd;
    logic       wr;
    logic [3:0] ofs;
  } cpr_tf_sel_t;

endpackage : cpr_pkg

//--- design/cpr_card_regs.sv
// Purpose: attribute registers and task file decode of a flash card port
// Assumes: host strobes synchronous to clk_i, one strobe pair per access
// Notes:   writes take effect on each clock with a write strobe low
`timescale 1ns/1ns
`default_nettype none
module cpr_card_regs
  import cpr_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          power_on_i,
  input  wire cpr_host_bus_t bus_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          ready_busy_state_i,
  input  wire logic          write_protect_state_i,
  output logic [7:0]         attr_rdata_o,
  output logic               attr_rvalid_o,
  output cpr_tf_sel_t        tf_sel_o,
  output cpr_map_t           map_o,
  output logic               copy_number_o,
  output logic               soft_reset_o
);

  logic [7:0] pin_repl;
  logic [7:0] next_pin_repl;
  logic [7:0] sock_copy;
  logic [7:0] next_sock_copy;
  logic [7:0] cfg_opt;
  logic [7:0] next_cfg_opt;
  logic       rdy_prev;
  logic       wp_prev;
  logic       ide_latched;
  logic       next_ide_latched;
  cpr_map_t   next_map;
  cpr_tf_sel_t next_tf_sel;
  logic [7:0] next_attr_rdata;
  logic       next_attr_rvalid;

  logic attr_space;
  logic attr_wr;
  logic attr_rd;

  function automatic cpr_map_t map_of(input logic [5:0] idx,
                                      input logic       ide);
    if (ide) begin
      map_of = CPR_MAP_IDE;
    end else begin
      case (idx)
        CPR_IDX_MEMORY:    map_of = CPR_MAP_MEMORY;
        CPR_IDX_CONTIG:    map_of = CPR_MAP_CONTIG;
        CPR_IDX_PRIMARY:   map_of = CPR_MAP_PRIMARY;
        CPR_IDX_SECONDARY: map_of = CPR_MAP_SECOND;
        default:           map_of = CPR_MAP_MEMORY;
      endcase
    end
  endfunction : map_of

  function automatic logic attr_hit(input logic [10:0] a,
                                    input logic [10:0] base);
    attr_hit = (a == base);
  endfunction : attr_hit

  // attribute space: register select low, memory strobes, not ide
  assign attr_space = !bus_i.reg_sel_n && !ide_latched;
  assign attr_wr = attr_space && !bus_i.we_n && bus_i.addr[10:9] == 2'b01;
  assign attr_rd = attr_space && !bus_i.oe_n && bus_i.addr[10:9] == 2'b01;

  cpr_tf_decode cpr_tf_decode_i (
    .map_i (map_o),
    .bus_i (bus_i),
    .sel_o (next_tf_sel)
  );

  always_comb begin
    next_pin_repl  = pin_repl;
    next_sock_copy = sock_copy;
    next_cfg_opt   = cfg_opt;
    next_ide_latched = ide_latched;
    if (attr_wr && attr_hit(bus_i.addr, CPR_PIN_REPL_ADDR)) begin
      next_pin_repl[CPR_RDY_CHG_BIT] = wdata_i[CPR_RDY_CHG_BIT];
      next_pin_repl[CPR_WP_CHG_BIT]  = wdata_i[CPR_WP_CHG_BIT];
    end
    if (ready_busy_state_i != rdy_prev) begin
      next_pin_repl[CPR_RDY_CHG_BIT] = 1'b1;
    end
    if (write_protect_state_i != wp_prev) begin
      next_pin_repl[CPR_WP_CHG_BIT] = 1'b1;
    end
    next_pin_repl[CPR_RDY_BIT] = ready_busy_state_i;
    next_pin_repl[CPR_WP_BIT]  = write_protect_state_i;
    next_pin_repl[7:6] = 2'b00;
    next_pin_repl[3:2] = CPR_PIN_FIXED_ONES[3:2];
    if (attr_wr && attr_hit(bus_i.addr, CPR_SOCK_COPY_ADDR)) begin
      next_sock_copy = wdata_i;
    end
    if (attr_wr && attr_hit(bus_i.addr, CPR_CFG_OPT_ADDR)) begin
      next_cfg_opt = wdata_i;
    end
    // catch output enable at power up
    if (power_on_i) begin
      next_ide_latched = !bus_i.oe_n;
      next_cfg_opt     = CPR_CFG_OPT_RST;
    end
    // soft reset holds mode field clear
    if (next_cfg_opt[7]) begin
      next_cfg_opt[5:0] = CPR_IDX_MEMORY;
    end
    next_map = map_of(next_cfg_opt[5:0], next_ide_latched);
  end

  always_comb begin
    next_attr_rdata  = 8'h00;
    next_attr_rvalid = attr_rd;
    if (attr_rd) begin
      case (bus_i.addr)
        CPR_CFG_OPT_ADDR:   next_attr_rdata = cfg_opt;
        CPR_PIN_REPL_ADDR:  next_attr_rdata = pin_repl;
        CPR_SOCK_COPY_ADDR: next_attr_rdata = sock_copy;
        default:            next_attr_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_repl      <= CPR_PIN_REPL_RST;
      sock_copy     <= CPR_SOCK_COPY_RST;
      cfg_opt       <= CPR_CFG_OPT_RST;
      ide_latched   <= 1'b0;
      map_o         <= CPR_MAP_MEMORY;
      rdy_prev      <= 1'b0;
      wp_prev       <= 1'b0;
      tf_sel_o      <= '0;
      attr_rdata_o  <= 8'h00;
      attr_rvalid_o <= 1'b0;
      copy_number_o <= 1'b0;
      soft_reset_o  <= 1'b0;
    end else begin
      pin_repl      <= next_pin_repl;
      sock_copy     <= next_sock_copy;
      cfg_opt       <= next_cfg_opt;
      ide_latched   <= next_ide_latched;
      map_o         <= next_map;
      rdy_prev      <= ready_busy_state_i;
      wp_prev       <= write_protect_state_i;
      tf_sel_o      <= next_tf_sel;
      attr_rdata_o  <= next_attr_rdata;
      attr_rvalid_o <= next_attr_rvalid;
      copy_number_o <= next_sock_copy[CPR_COPY_BIT];
      soft_reset_o  <= next_cfg_opt[7];
    end
  end

  property p_fixed_bits;
    @(posedge clk_i) disable iff (rst_i)
      pin_repl[7:6] == 2'b00 && pin_repl[3:2] == 2'b11;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("pin replacement fixed bits wrong");

  property p_rdy_chg;
    @(posedge clk_i) disable iff (rst_i)
      (ready_busy_state_i != rdy_prev) |=> pin_repl[CPR_RDY_CHG_BIT];
  endproperty
  a_rdy_chg: assert property (p_rdy_chg)
    else $error("ready change flag not set");

  property p_wp_chg;
    @(posedge clk_i) disable iff (rst_i)
      (write_protect_state_i != wp_prev) |=> pin_repl[CPR_WP_CHG_BIT];
  endproperty
  a_wp_chg: assert property (p_wp_chg)
    else $error("protect change flag not set");

  property p_rdy_mirror;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> pin_repl[CPR_RDY_BIT] == $past(ready_busy_state_i);
  endproperty
  a_rdy_mirror: assert property (p_rdy_mirror)
    else $error("ready bit does not mirror state");

  property p_wp_mirror;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> pin_repl[CPR_WP_BIT] == $past(write_protect_state_i);
  endproperty
  a_wp_mirror: assert property (p_wp_mirror)
    else $error("protect bit does not mirror state");

  property p_sock_write;
    @(posedge clk_i) disable iff (rst_i)
      (attr_wr && bus_i.addr == CPR_SOCK_COPY_ADDR)
        |=> sock_copy == $past(wdata_i) ##1 copy_number_o == sock_copy[4];
  endproperty
  a_sock_write: assert property (p_sock_write)
    else $error("socket and copy write lost");

  property p_soft_mode;
    @(posedge clk_i) disable iff (rst_i)
      cfg_opt[7] |-> cfg_opt[5:0] == CPR_IDX_MEMORY
                     && (ide_latched || map_o == CPR_MAP_MEMORY);
  endproperty
  a_soft_mode: assert property (p_soft_mode)
    else $error("mode field not cleared on soft reset");

  property p_map_follow;
    @(posedge clk_i) disable iff (rst_i)
      !ide_latched && cfg_opt[5:0] == CPR_IDX_PRIMARY
        |-> map_o == CPR_MAP_PRIMARY;
  endproperty
  a_map_follow: assert property (p_map_follow)
    else $error("map does not follow mode field");

  property p_ide_map;
    @(posedge clk_i) disable iff (rst_i)
      ide_latched |-> map_o == CPR_MAP_IDE;
  endproperty
  a_ide_map: assert property (p_ide_map)
    else $error("true ide map not selected");

endmodule : cpr_card_regs
`default_nettype wire

//--- design/cpr_tf_decode.sv
// Purpose: combinational task file address decode for one access
// Assumes: strobes already qualified, register select active low
// Notes:   output is a cycle-fresh selection, registered by the top
`timescale 1ns/1ns
`default_nettype none
module cpr_tf_decode
  import cpr_pkg::*;
(
  input  wire cpr_map_t      map_i,
  input  wire cpr_host_bus_t bus_i,
  output cpr_tf_sel_t        sel_o
);

  logic mem_rd;
  logic mem_wr;
  logic io_rd;
  logic io_wr;

  assign mem_rd = ~bus_i.oe_n;
  assign mem_wr = ~bus_i.we_n;
  assign io_rd  = ~bus_i.io_read_strobe_n;
  assign io_wr  = ~bus_i.io_write_strobe_n;

  always_comb begin
    sel_o = '0;
    case (map_i)
      CPR_MAP_MEMORY: begin
        if (bus_i.reg_sel_n) begin
          sel_o.rd = mem_rd;
          sel_o.wr = mem_wr;
          if (bus_i.addr[10]) begin
            sel_o.hit = 1'b1;
            sel_o.ofs = bus_i.addr[0] ? CPR_OFS_DUP_ODD : CPR_OFS_DUP_EVEN;
          end else begin
            sel_o.ofs = bus_i.addr[3:0];
            sel_o.hit = !(bus_i.addr[3] && bus_i.addr[2:0] inside
                          {3'h2, 3'h3, 3'h4})
                        && !(bus_i.addr[3:0] == CPR_OFS_DRV_ADDR && mem_wr);
          end
        end
      end
      CPR_MAP_CONTIG: begin
        if (bus_i.reg_sel_n == 1'b0) begin
          sel_o.rd  = io_rd;
          sel_o.wr  = io_wr;
          sel_o.ofs = bus_i.addr[3:0];
          sel_o.hit = !(bus_i.addr[3] && bus_i.addr[2:0] inside
                        {3'h2, 3'h3, 3'h4})
                      && bus_i.addr[3:0] != CPR_OFS_DRV_ADDR;
        end
      end
      CPR_MAP_PRIMARY: begin
        if (!bus_i.reg_sel_n && !bus_i.addr[3]) begin
          sel_o.rd = io_rd;
          sel_o.wr = io_wr;
          if (bus_i.addr[9:4] == CPR_PRI_HI_1F) begin
            sel_o.hit = 1'b1;
            sel_o.ofs = {1'b0, bus_i.addr[2:0]};
          end else if (bus_i.addr[9:4] == CPR_PRI_HI_3F
                       && bus_i.addr[2:1] == 2'b11) begin
            sel_o.hit = !(bus_i.addr[0] && io_wr);
            sel_o.ofs = bus_i.addr[0] ? CPR_OFS_DRV_ADDR : CPR_OFS_ALT;
          end
        end
      end
      default: sel_o = '0;
    endcase
    if (!(sel_o.rd || sel_o.wr)) begin
      sel_o.hit = 1'b0;
    end
  end

endmodule : cpr_tf_decode
`default_nettype wire

//--- test/cpr_card_regs_tb_top.sv
// Purpose: self-checking bench for the card register decode block
// Assumes: host model makes every access, one at a time
// Notes:   expectations come from the register layout and decode maps
`timescale 1ns/1ns
`default_nettype none
module cpr_card_regs_tb_top;
  import cpr_pkg::*;
  logic          clk_i      = 1'b0;
  logic          rst_i      = 1'b1;
  logic          power_on_i = 1'b1;
  logic          rdy        = 1'b0;
  logic          wp         = 1'b0;
  cpr_host_bus_t bus;
  logic [7:0]    wdata;
  logic [7:0]    attr_rdata_o;
  logic          attr_rvalid_o;
  cpr_tf_sel_t   tf_sel_o;
  cpr_map_t      map_o;
  logic          copy_number_o;
  logic          soft_reset_o;
  int            n_errors   = 0;
  int            n_compared = 0;

  always #20 clk_i = ~clk_i;

  cpr_host_model cpr_host_model_i (.clk_i(clk_i), .bus_o(bus),
                                   .wdata_o(wdata));
  cpr_card_regs cpr_card_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .power_on_i(power_on_i), .bus_i(bus),
    .wdata_i(wdata), .ready_busy_state_i(rdy),
    .write_protect_state_i(wp), .attr_rdata_o(attr_rdata_o),
    .attr_rvalid_o(attr_rvalid_o), .tf_sel_o(tf_sel_o), .map_o(map_o),
    .copy_number_o(copy_number_o), .soft_reset_o(soft_reset_o));

  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte

  task automatic chk_sel(input string what, input cpr_tf_sel_t e,
                         input cpr_tf_sel_t g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_sel

  function automatic cpr_tf_sel_t sel(input logic h, input logic r,
                                      input logic w, input logic [3:0] o);
    return {h, r, w, o};
  endfunction : sel

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    cpr_host_model_i.access(2'd1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    cpr_host_model_i.access(2'd0, 1'b0, a, 8'h00);
    #1;
    chk_byte("attr valid", 8'h01, {7'h00, attr_rvalid_o});
    chk_byte("attr data", e, attr_rdata_o);
  endtask : rd

  task automatic tf(input logic [1:0] k, input logic rs,
                    input logic [10:0] a, input cpr_tf_sel_t e);
    cpr_host_model_i.access(k, rs, a, 8'h5a);
    #1;
    if (e.hit) begin
      chk_sel("tf select", e, tf_sel_o);
    end else begin
      chk_byte("tf hit", 8'h00, {7'h00, tf_sel_o.hit});
    end
  endtask : tf

  task automatic chk_map(input cpr_map_t m);
    chk_byte("map", {5'h00, m}, {5'h00, map_o});
  endtask : chk_map

  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i      <= 1'b0;
    power_on_i <= 1'b0;
    rd(11'h204, 8'h0c);
    rdy <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(11'h204, 8'h2e);
    wr(11'h204, 8'h00);
    rd(11'h204, 8'h0e);
    wp <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(11'h204, 8'h1f);
    wr(11'h204, 8'hff);
    rd(11'h204, 8'h3f);
    wr(11'h204, 8'h00);
    rdy <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(11'h204, 8'h2d);
    rd(11'h206, 8'h00);
    wr(11'h206, 8'h10);
    rd(11'h206, 8'h10);
    chk_byte("copy", 8'h01, {7'h00, copy_number_o});
    rd(11'h208, 8'h00);
    chk_map(CPR_MAP_MEMORY);
    for (int i = 0; i < 16; i++) begin
      tf(2'd0, 1'b1, {7'h00, i[3:0]},
         sel(!(i inside {10, 11, 12}), 1'b1, 1'b0, i[3:0]));
    end
    tf(2'd1, 1'b1, 11'h00f, sel(1'b0, 1'b0, 1'b1, 4'hf));
    tf(2'd0, 1'b1, 11'h7fe, sel(1'b1, 1'b1, 1'b0, 4'h8));
    tf(2'd1, 1'b1, 11'h6a9, sel(1'b1, 1'b0, 1'b1, 4'h9));
    tf(2'd0, 1'b0, 11'h001, sel(1'b0, 1'b1, 1'b0, 4'h1));
    wr(11'h200, 8'h01);
    rd(11'h200, 8'h01);
    chk_map(CPR_MAP_CONTIG);
    tf(2'd2, 1'b0, 11'h7f3, sel(1'b1, 1'b1, 1'b0, 4'h3));
    tf(2'd3, 1'b0, 11'h5ae, sel(1'b1, 1'b0, 1'b1, 4'he));
    tf(2'd2, 1'b0, 11'h00f, sel(1'b0, 1'b1, 1'b0, 4'hf));
    tf(2'd2, 1'b1, 11'h003, sel(1'b0, 1'b1, 1'b0, 4'h3));
    wr(11'h200, 8'h02);
    #1;
    chk_map(CPR_MAP_PRIMARY);
    tf(2'd2, 1'b0, 11'h1f5, sel(1'b1, 1'b1, 1'b0, 4'h5));
    tf(2'd3, 1'b0, 11'h5f0, sel(1'b1, 1'b0, 1'b1, 4'h0));
    tf(2'd2, 1'b0, 11'h3f6, sel(1'b1, 1'b1, 1'b0, 4'he));
    tf(2'd2, 1'b0, 11'h3f7, sel(1'b1, 1'b1, 1'b0, 4'hf));
    tf(2'd3, 1'b0, 11'h3f7, sel(1'b0, 1'b0, 1'b1, 4'hf));
    tf(2'd2, 1'b0, 11'h1f8, sel(1'b0, 1'b1, 1'b0, 4'h8));
    tf(2'd2, 1'b0, 11'h2f0, sel(1'b0, 1'b1, 1'b0, 4'h0));
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(11'h200, 8'h00);
    chk_map(CPR_MAP_MEMORY);
    rd(11'h206, 8'h00);
    rd(11'h204, 8'h1d);
    wr(11'h200, 8'h82);
    rd(11'h200, 8'h80);
    chk_byte("soft reset", 8'h01, {7'h00, soft_reset_o});
    chk_map(CPR_MAP_MEMORY);
    wr(11'h200, 8'h00);
    cpr_host_model_i.set_oe(1'b0);
    power_on_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    power_on_i <= 1'b0;
    cpr_host_model_i.set_oe(1'b1);
    repeat (2) @(posedge clk_i);
    #1;
    chk_map(CPR_MAP_IDE);
    tf(2'd0, 1'b1, 11'h002, sel(1'b0, 1'b1, 1'b0, 4'h2));
    final_report();
  end
endmodule : cpr_card_regs_tb_top
`default_nettype wire

//--- test/cpr_host_model.sv
// Purpose: host socket controller model that drives the card strobes
// Assumes: one access at a time, changes just after a rising edge
// Notes:   released address and data lines show the inverse of last value
`timescale 1ns/1ns
`default_nettype none
module cpr_host_model
  import cpr_pkg::*;
(
  input  wire logic     clk_i,
  output cpr_host_bus_t bus_o,
  output logic [7:0]    wdata_o
);
  initial begin
    bus_o   = {11'h000, 5'h1f};
    wdata_o = 8'h00;
  end

  // one strobe pair
  // kind 0 memory read, 1 memory write, 2 io read, 3 io write
  task automatic access(input logic [1:0] kind, input logic rs,
                        input logic [10:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    bus_o   <= {addr, rs, kind != 2'd0, kind != 2'd1, kind != 2'd2,
                kind != 2'd3};
    wdata_o <= data;
    @(posedge clk_i);
    bus_o   <= {~addr, rs, 4'hf};
    wdata_o <= ~data;
  endtask : access

  task automatic set_oe(input logic v);
    @(posedge clk_i);
    bus_o.oe_n <= v;
  endtask : set_oe
endmodule : cpr_host_model
`default_nettype wire
